// >>> dv/chipset_model.sv
// Purpose: chipset side: request pin, merged ready, nmi block decoded from the pin
// Assumes: pin pulled up when nobody drives it low
// Notes:   ready answers one cycle after either strobe
`timescale 1ns/1ps
`default_nettype none
module chipset_model (
  // clock and bench request
  input  wire logic i_clk,
  input  wire logic i_req,
  // device side
  input  wire logic i_dev_irq_n,
  input  wire logic i_dev_oe_n,
  input  wire logic i_smm_stb,
  input  wire logic i_norm_stb,
  // resolved lines
  output logic      o_irq_n,
  output logic      o_ready_n,
  output logic      o_nmi_block
);
  logic smm_rdy_n_q  = 1'b1;
  logic norm_rdy_n_q = 1'b1;
  assign o_irq_n = !((!i_dev_oe_n && !i_dev_irq_n) || i_req);
  always_ff @(posedge i_clk) begin
    smm_rdy_n_q  <= !i_smm_stb;
    norm_rdy_n_q <= !i_norm_stb;
  end
  assign o_ready_n = smm_rdy_n_q & norm_rdy_n_q;
  assign o_nmi_block = !o_irq_n;
endmodule
`default_nettype wire

// >>> dv/smm_chk.sv
// Purpose: port checks for the management entry/exit block
// Assumes: I_CE held high, region inputs stable
// Notes:   bound into smm_entry_exit below
`timescale 1ns/1ps
`default_nettype none
module smm_chk (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESET_N,
  // inputs watched
  input  wire logic        I_ACC_REQ,
  input  wire logic [31:0] I_ACC_ADDR,
  input  wire logic        I_ACC_FETCH,
  input  wire logic        I_ACC_CS_PREFIX,
  input  wire logic        I_SPECIAL_INSN,
  input  wire logic        I_IN_REGION_EXEC,
  input  wire logic [31:0] I_REGION_BASE,
  input  wire logic [31:0] I_REGION_SIZE,
  // outputs watched
  input  wire logic        O_SYS_MGMT_IRQ_N,
  input  wire logic        O_SYS_MGMT_IRQ_OE_N,
  input  wire logic        O_SMM_ADDR_STROBE,
  input  wire logic        O_NORMAL_ADDR_STROBE,
  input  wire logic        O_ACC_CACHEABLE,
  input  wire logic        O_ACC_A20_FORCE,
  input  wire logic        O_HDR_WE,
  input  wire logic [31:0] O_HDR_ADDR,
  input  wire logic        O_LOAD_ENTRY,
  input  wire logic [31:0] O_IP,
  input  wire logic [31:0] O_CS_BASE,
  input  wire logic [31:0] O_CS_LIMIT,
  input  wire logic        O_NMI_ONLY,
  input  wire logic        O_UNDEF_OPCODE,
  input  wire logic        O_IN_PROGRESS,
  input  wire logic        O_MAIN_MEM_ACCESS_EN,
  input  wire logic        O_SMM_SPACE_ACCESS_EN
);
  logic [31:0] hdr_base;
  logic        in_reg;
  assign hdr_base = I_REGION_BASE + I_REGION_SIZE - smm_pkg::HDR_START_OFS;
  assign in_reg = I_ACC_ADDR >= I_REGION_BASE &&
                  I_ACC_ADDR - I_REGION_BASE < I_REGION_SIZE;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  sequence save_first;
    O_HDR_WE && O_HDR_ADDR == hdr_base;
  endsequence
  sequence save_last;
    O_HDR_WE && O_HDR_ADDR == hdr_base + 32'h0000_002C;
  endsequence
  hdr_save_a: assert property (
    $rose(O_IN_PROGRESS) |-> ##1 save_first ##11 save_last ##0 O_LOAD_ENTRY)
    else $error("header save order wrong");
  entry_load_a: assert property (
    O_LOAD_ENTRY |-> O_IP == smm_pkg::IP_ENTRY && O_NMI_ONLY &&
      O_CS_BASE == I_REGION_BASE && O_CS_LIMIT == I_REGION_SIZE)
    else $error("entry load values wrong");
  pin_drive_a: assert property (
    O_IN_PROGRESS |-> !O_SYS_MGMT_IRQ_N && !O_SYS_MGMT_IRQ_OE_N)
    else $error("pin not driven low in handler");
  exit_high_a: assert property (
    $fell(O_IN_PROGRESS) |-> (O_SYS_MGMT_IRQ_N && !O_SYS_MGMT_IRQ_OE_N)[*2]
      ##1 O_SYS_MGMT_IRQ_OE_N)
    else $error("exit pin pulse wrong");
  smm_route_a: assert property (
    I_ACC_REQ && O_IN_PROGRESS && in_reg && (I_ACC_FETCH ||
      I_ACC_CS_PREFIX || !O_MAIN_MEM_ACCESS_EN)
      |=> O_SMM_ADDR_STROBE && !O_NORMAL_ADDR_STROBE)
    else $error("region access not on management strobe");
  main_route_a: assert property (
    I_ACC_REQ && O_IN_PROGRESS && in_reg && !I_ACC_FETCH &&
      !I_ACC_CS_PREFIX && O_MAIN_MEM_ACCESS_EN
      |=> O_NORMAL_ADDR_STROBE && !O_SMM_ADDR_STROBE)
    else $error("data access not on normal strobe");
  no_cache_a: assert property (
    O_SMM_ADDR_STROBE |-> !O_ACC_CACHEABLE && O_ACC_A20_FORCE)
    else $error("management access cached or masked");
  undef_raise_a: assert property (
    I_SPECIAL_INSN && !I_IN_REGION_EXEC && !O_SMM_SPACE_ACCESS_EN &&
      !O_IN_PROGRESS |=> O_UNDEF_OPCODE)
    else $error("no undefined opcode");
  special_ok_a: assert property (
    I_SPECIAL_INSN && (O_SMM_SPACE_ACCESS_EN || O_IN_PROGRESS)
      |=> !O_UNDEF_OPCODE)
    else $error("allowed instruction refused");
endmodule
bind smm_entry_exit smm_chk u_chk (.*);
`default_nettype wire

// >>> dv/tb.sv
// Purpose: directed bench for the management entry/exit block
// Assumes: chipset model resolves the request pin
// Notes:   header words captured from the write port
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] BASE = 32'h000C_8000;
  localparam logic [31:0] SIZE = 32'h0000_2000;
  localparam logic [31:0] HB   = BASE + SIZE - 32'h0000_0030;
  logic        clk = 1'b0, rst_n = 1'b0, req = 1'b0, rep = 1'b0;
  logic        io_w = 1'b0, r_insn = 1'b0, spec_i = 1'b0, in_exec = 1'b0;
  logic        rwe = 1'b0, io_we = 1'b0, io_re = 1'b0, acc_req = 1'b0;
  logic        fetch = 1'b0, csp = 1'b0, a20_n = 1'b1;
  logic [31:0] flags = 32'h0, ctrl0 = 32'h0, debug = 32'h0, idx = 32'h0;
  logic [31:0] cur_ip = 32'h0, resume_ip = 32'h0, rdata = 32'h0;
  logic [31:0] acc_addr = 32'h0;
  logic [15:0] cs_sel = 16'h0, io_addr = 16'h0;
  logic [63:0] cs_desc = 64'h0;
  logic [7:0]  io_wdata = 8'h00, io_rdata;
  logic        irq_w, dev_irq_n, dev_oe_n, rdy_n, io_hit, smm_stb;
  logic        norm_stb, hdr_we, ld_ent, ld_res, undef, in_prog, main_mem_access_en;
  logic        smm_space_access_en;
  logic [31:0] hdr_addr, hdr_wdata, o_flags, o_ctrl0, o_debug, o_ip;
  logic [15:0] o_cs_sel;
  logic [31:0] hdr [0:11];
  int          errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #50 clk = ~clk;
  chipset_model u_cs (.i_clk(clk), .i_req(req), .i_dev_irq_n(dev_irq_n),
    .i_dev_oe_n(dev_oe_n), .i_smm_stb(smm_stb), .i_norm_stb(norm_stb),
    .o_irq_n(irq_w), .o_ready_n(rdy_n), .o_nmi_block());
  smm_entry_exit dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_CE(1'b1),
    .I_SYS_MGMT_IRQ_N(irq_w), .O_SYS_MGMT_IRQ_N(dev_irq_n),
    .O_SYS_MGMT_IRQ_OE_N(dev_oe_n), .I_IRQ_PIN_EN(1'b1),
    .I_REGION_BASE(BASE), .I_REGION_SIZE(SIZE), .I_FLAGS(flags),
    .I_CTRL0(ctrl0), .I_DEBUG(debug), .I_CUR_IP(cur_ip),
    .I_RESUME_IP(resume_ip), .I_CS_SEL(cs_sel), .I_CS_DESC(cs_desc),
    .I_INDEX_VAL(idx), .I_REP_PREFIX(rep), .I_IO_WRITE(io_w),
    .I_RESUME_INSN(r_insn), .I_SPECIAL_INSN(spec_i),
    .I_IN_REGION_EXEC(in_exec), .I_HDR_RESUME_WE(rwe),
    .I_HDR_RESUME_DATA(rdata), .I_IO_WE(io_we), .I_IO_RE(io_re),
    .I_IO_ADDR(io_addr), .I_IO_WDATA(io_wdata), .O_IO_RDATA(io_rdata),
    .O_IO_HIT(io_hit), .I_ACC_REQ(acc_req), .I_ACC_ADDR(acc_addr),
    .I_ACC_FETCH(fetch), .I_ACC_CS_PREFIX(csp),
    .I_ADDR_BIT20_MASK_N(a20_n), .I_BUS_READY_N(rdy_n),
    .O_SMM_ADDR_STROBE(smm_stb), .O_NORMAL_ADDR_STROBE(norm_stb),
    .O_ACC_CACHEABLE(), .O_ACC_A20_FORCE(), .O_FETCH_FAULT(),
    .O_HDR_WE(hdr_we), .O_HDR_ADDR(hdr_addr), .O_HDR_WDATA(hdr_wdata),
    .O_LOAD_ENTRY(ld_ent), .O_LOAD_RESUME(ld_res), .O_FLAGS(o_flags),
    .O_CTRL0(o_ctrl0), .O_DEBUG(o_debug), .O_IP(o_ip),
    .O_CS_SEL(o_cs_sel), .O_CS_BASE(), .O_CS_LIMIT(), .O_NMI_ONLY(),
    .O_UNDEF_OPCODE(undef), .O_IN_PROGRESS(in_prog),
    .O_MAIN_MEM_ACCESS_EN(main_mem_access_en), .O_SMM_SPACE_ACCESS_EN(smm_space_access_en));
  always @(posedge clk) begin
    if (hdr_we)
      hdr[4'((hdr_addr - HB) >> 2)] <= hdr_wdata;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic io(input logic we, input logic [15:0] a,
                    input logic [7:0] d, input logic hit);
    @(posedge clk);
    io_we <= we;
    io_re <= !we;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_we <= 1'b0;
    io_re <= 1'b0;
    #1;
    if (!we)
      chk(io_hit, hit);
    if (!we && hit)
      chk(io_rdata, d);
  endtask
  task automatic acc(input logic [31:0] a, input logic f, input logic c,
                     input logic smm);
    @(posedge clk);
    acc_req <= 1'b1;
    acc_addr <= a;
    fetch <= f;
    csp <= c;
    a20_n <= ~a20_n;
    @(posedge clk);
    acc_req <= 1'b0;
    #1;
    chk(smm_stb, smm);
    chk(norm_stb, !smm);
  endtask
  task automatic spec(input logic inr, input logic exp);
    @(posedge clk);
    spec_i <= 1'b1;
    in_exec <= inr;
    @(posedge clk);
    spec_i <= 1'b0;
    #1;
    chk(undef, exp);
  endtask
  task automatic enter(input logic [7:0] k, input logic p, input logic w);
    @(posedge clk);
    {rep, io_w} <= {p, w};
    {flags, ctrl0} <= {24'h000002, k, 24'h000011, k};
    {debug, idx} <= {24'h000007, k, 24'h00CC00, k};
    {cur_ip, resume_ip} <= {24'h0001A0, k, 24'h0001B0, k};
    cs_sel <= {8'hF0, k};
    cs_desc <= {32'h00CF_9B00, 24'h00FFFF, k};
    req <= 1'b1;
    repeat (20) begin @(posedge clk); #1; if (in_prog === 1'b1) break; end
    chk(in_prog, 1'b1);
    @(posedge clk);
    req <= 1'b0;
    repeat (40) begin @(posedge clk); #1; if (ld_ent === 1'b1) break; end
    chk(ld_ent, 1'b1);
    chk({o_flags, o_ctrl0}, {smm_pkg::FLAGS_RST, smm_pkg::CTRL0_RST});
    chk(o_debug, smm_pkg::DEBUG_RST);
    @(posedge clk);
    #1;
    chk({hdr[smm_pkg::W_DEBUG], hdr[smm_pkg::W_FLAGS]}, {debug, flags});
    chk({hdr[smm_pkg::W_CTRL0], hdr[smm_pkg::W_CS_SEL][15:0]},
        {ctrl0, cs_sel});
    chk({hdr[smm_pkg::W_CUR_IP], hdr[smm_pkg::W_RESUME]},
        {cur_ip, resume_ip});
    chk(hdr[smm_pkg::W_INDEX], idx);
    chk({hdr[smm_pkg::W_DESC_HI], hdr[smm_pkg::W_DESC_LO]}, cs_desc);
    chk(hdr[smm_pkg::W_IND_BITS][1:0], {p, w});
  endtask
  task automatic resume(input logic edit);
    @(posedge clk);
    rwe <= edit;
    rdata <= cur_ip;
    @(posedge clk);
    rwe <= 1'b0;
    r_insn <= 1'b1;
    @(posedge clk);
    r_insn <= 1'b0;
    repeat (40) begin @(posedge clk); #1; if (ld_res === 1'b1) break; end
    chk(ld_res, 1'b1);
    chk(o_ip, edit ? cur_ip : resume_ip);
    chk({o_flags, o_ctrl0}, {flags, ctrl0});
    chk(o_debug, debug);
    chk(o_cs_sel, cs_sel);
    repeat (4) @(posedge clk);
    #1;
    chk({in_prog, irq_w, dev_oe_n}, 3'b011);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({in_prog, dev_irq_n, dev_oe_n}, 3'b011);
    chk(o_flags, smm_pkg::FLAGS_RST);
    io(1'b0, 16'h0023, 8'h00, 1'b0);
    io(1'b1, smm_pkg::IO_INDEX_PORT, smm_pkg::CFG1_INDEX, 1'b0);
    io(1'b1, smm_pkg::IO_DATA_PORT, 8'h08, 1'b0);
    io(1'b1, smm_pkg::IO_INDEX_PORT, smm_pkg::CFG1_INDEX, 1'b0);
    io(1'b0, smm_pkg::IO_DATA_PORT, 8'h08, 1'b1);
    chk({main_mem_access_en, smm_space_access_en}, 2'b10);
    $display("test config done");
    spec(1'b0, 1'b1);
    spec(1'b1, 1'b0);
    acc(BASE + 32'h10, 1'b1, 1'b0, 1'b0);
    io(1'b1, smm_pkg::IO_INDEX_PORT, smm_pkg::CFG1_INDEX, 1'b0);
    io(1'b1, smm_pkg::IO_DATA_PORT, 8'h0C, 1'b0);
    spec(1'b0, 1'b0);
    acc(BASE + 32'h20, 1'b1, 1'b0, 1'b1);
    $display("test normal mode done");
    enter(8'h5A, 1'b1, 1'b0);
    acc(BASE + 32'h40, 1'b0, 1'b0, 1'b0);
    acc(BASE + 32'h44, 1'b1, 1'b0, 1'b1);
    acc(BASE + 32'h48, 1'b0, 1'b1, 1'b1);
    acc(BASE - 32'h4, 1'b1, 1'b0, 1'b0);
    spec(1'b0, 1'b0);
    resume(1'b0);
    $display("test entry one done");
    io(1'b1, smm_pkg::IO_INDEX_PORT, smm_pkg::CFG1_INDEX, 1'b0);
    io(1'b1, smm_pkg::IO_DATA_PORT, 8'h00, 1'b0);
    enter(8'hA3, 1'b0, 1'b1);
    acc(BASE + SIZE - 32'h4, 1'b0, 1'b0, 1'b1);
    resume(1'b1);
    $display("test entry two done");
    finish_test();
  end
endmodule
`default_nettype wire

// >>> rtl/hdr_mem.sv
// Purpose: small header word store with registered read data
// Assumes: at most one write plus the one read per cycle
// Notes:   mirrors the in-memory header image
`timescale 1ns/1ps
`default_nettype none
module hdr_mem (
  // clock
  input  wire logic        i_clk,
  input  wire logic        i_ce,
  // write side
  input  wire logic        i_we,
  input  wire logic [3:0]  i_waddr,
  input  wire logic [31:0] i_wdata,
  // read side
  input  wire logic [3:0]  i_raddr,
  output logic      [31:0] o_rdata
);
  logic [31:0] mem [0:smm_pkg::HDR_WORDS-1];
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_we) begin
        mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
    end
  end
endmodule
`default_nettype wire

// >>> rtl/smm_entry_exit.sv
// Purpose: management-mode entry save, resume restore, strobe steering
// Assumes: inputs synchronous to I_CLK (doubled clock, 10 MHz)
// Notes:   header words go out on the memory write port and a copy
//          is kept locally so resume needs no bus read
`timescale 1ns/1ps
`default_nettype none
module smm_entry_exit (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESET_N,
  input  wire logic        I_CE,
  // management interrupt pin, three-signal form
  input  wire logic        I_SYS_MGMT_IRQ_N,
  output logic             O_SYS_MGMT_IRQ_N,
  output logic             O_SYS_MGMT_IRQ_OE_N,
  // region setup
  input  wire logic        I_IRQ_PIN_EN,
  input  wire logic [31:0] I_REGION_BASE,
  input  wire logic [31:0] I_REGION_SIZE,
  // core state at entry
  input  wire logic [31:0] I_FLAGS,
  input  wire logic [31:0] I_CTRL0,
  input  wire logic [31:0] I_DEBUG,
  input  wire logic [31:0] I_CUR_IP,
  input  wire logic [31:0] I_RESUME_IP,
  input  wire logic [15:0] I_CS_SEL,
  input  wire logic [63:0] I_CS_DESC,
  input  wire logic [31:0] I_INDEX_VAL,
  input  wire logic        I_REP_PREFIX,
  input  wire logic        I_IO_WRITE,
  // core instruction events
  input  wire logic        I_RESUME_INSN,
  input  wire logic        I_SPECIAL_INSN,
  input  wire logic        I_IN_REGION_EXEC,
  // header edits by the handler (resume pointer only)
  input  wire logic        I_HDR_RESUME_WE,
  input  wire logic [31:0] I_HDR_RESUME_DATA,
  // io cycles from the core
  input  wire logic        I_IO_WE,
  input  wire logic        I_IO_RE,
  input  wire logic [15:0] I_IO_ADDR,
  input  wire logic [7:0]  I_IO_WDATA,
  output logic      [7:0]  O_IO_RDATA,
  output logic             O_IO_HIT,
  // memory access classification
  input  wire logic        I_ACC_REQ,
  input  wire logic [31:0] I_ACC_ADDR,
  input  wire logic        I_ACC_FETCH,
  input  wire logic        I_ACC_CS_PREFIX,
  input  wire logic        I_ADDR_BIT20_MASK_N,
  input  wire logic        I_BUS_READY_N,
  output logic             O_SMM_ADDR_STROBE,
  output logic             O_NORMAL_ADDR_STROBE,
  output logic             O_ACC_CACHEABLE,
  output logic             O_ACC_A20_FORCE,
  output logic             O_FETCH_FAULT,
  // header write port to memory
  output logic             O_HDR_WE,
  output logic      [31:0] O_HDR_ADDR,
  output logic      [31:0] O_HDR_WDATA,
  // register loads to the core
  output logic             O_LOAD_ENTRY,
  output logic             O_LOAD_RESUME,
  output logic      [31:0] O_FLAGS,
  output logic      [31:0] O_CTRL0,
  output logic      [31:0] O_DEBUG,
  output logic      [31:0] O_IP,
  output logic      [15:0] O_CS_SEL,
  output logic      [31:0] O_CS_BASE,
  output logic      [31:0] O_CS_LIMIT,
  output logic             O_NMI_ONLY,
  output logic             O_UNDEF_OPCODE,
  // status
  output logic             O_IN_PROGRESS,
  output logic             O_MAIN_MEM_ACCESS_EN,
  output logic             O_SMM_SPACE_ACCESS_EN
);
  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    smm_pkg::seq_t seq;
    logic [2:0]    low_cnt;
    logic [2:0]    hi_cnt;
    logic [3:0]    widx;
    logic          in_prog;
    logic [7:0]    cfg1;
    logic          idx_sel;
    logic [7:0]    io_rdata;
    logic          io_hit;
    logic          hdr_we;
    logic [31:0]   hdr_addr;
    logic [31:0]   hdr_wdata;
    logic          ld_entry;
    logic          ld_resume;
    logic [31:0]   flags;
    logic [31:0]   ctrl0;
    logic [31:0]   debug;
    logic [31:0]   ip;
    logic [15:0]   cs_sel;
    logic [31:0]   cs_base;
    logic [31:0]   cs_limit;
    logic          undef;
    logic          smm_stb;
    logic          nrm_stb;
    logic          cacheable;
    logic          a20_force;
    logic          fetch_fault;
  } state_t;

  state_t      st_q;
  state_t      st_d;
  logic        mem_we;
  logic [3:0]  mem_waddr;
  logic [31:0] mem_wdata;
  logic [3:0]  mem_raddr;
  logic [31:0] mem_rdata;
  logic [31:0] hdr_base;
  logic [31:0] region_end;
  logic        in_region;
  logic [31:0] save_word;

  assign hdr_base   = I_REGION_BASE + I_REGION_SIZE - smm_pkg::HDR_START_OFS;
  assign region_end = I_REGION_BASE + I_REGION_SIZE;
  assign in_region  = (I_ACC_ADDR >= I_REGION_BASE) &&
                      (I_ACC_ADDR < region_end);

  // ----------------------------------------------------------------
  // header word selection
  // ----------------------------------------------------------------
  // header field packing
  always_comb begin
    case (st_q.widx)
      smm_pkg::W_DEBUG:    save_word = I_DEBUG;
      smm_pkg::W_FLAGS:    save_word = I_FLAGS;
      smm_pkg::W_CTRL0:    save_word = I_CTRL0;
      smm_pkg::W_CUR_IP:   save_word = I_CUR_IP;
      smm_pkg::W_INDEX:    save_word = I_INDEX_VAL;
      smm_pkg::W_RESUME:   save_word = I_RESUME_IP;
      smm_pkg::W_CS_SEL:   save_word = {16'h0000, I_CS_SEL};
      smm_pkg::W_DESC_LO:  save_word = I_CS_DESC[31:0];
      smm_pkg::W_DESC_HI:  save_word = I_CS_DESC[63:32];
      smm_pkg::W_IND_BITS: save_word = {30'h0000_0000, I_REP_PREFIX,
                                        I_IO_WRITE};
      default:             save_word = 32'h0000_0000;
    endcase
  end

  assign mem_we    = (st_q.seq == smm_pkg::ST_SAVE) ||
                     (I_HDR_RESUME_WE && st_q.in_prog);
  assign mem_waddr = (st_q.seq == smm_pkg::ST_SAVE) ? st_q.widx
                                                    : smm_pkg::W_RESUME;
  assign mem_wdata = (st_q.seq == smm_pkg::ST_SAVE) ? save_word
                                                    : I_HDR_RESUME_DATA;
  assign mem_raddr = st_q.widx;

  hdr_mem u_hdr (
    .i_clk   (I_CLK),
    .i_ce    (I_CE),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.hdr_we    = 1'b0;
    st_d.ld_entry  = 1'b0;
    st_d.ld_resume = 1'b0;
    st_d.undef     = 1'b0;
    st_d.io_hit    = 1'b0;
    case (st_q.seq)
      smm_pkg::ST_IDLE: begin
        // request must stay low four periods
        if (!I_SYS_MGMT_IRQ_N && I_IRQ_PIN_EN) begin
          if (st_q.low_cnt == smm_pkg::IRQ_MIN_LOW - 3'h1) begin
            st_d.in_prog = 1'b1;
            st_d.seq     = smm_pkg::ST_SAVE;
            st_d.widx    = 4'h0;
            st_d.low_cnt = 3'h0;
          end else begin
            st_d.low_cnt = st_q.low_cnt + 3'h1;
          end
        end else begin
          st_d.low_cnt = 3'h0;
        end
      end
      smm_pkg::ST_SAVE: begin
        // header written upward from top minus 30h
        st_d.hdr_we    = 1'b1;
        st_d.hdr_addr  = hdr_base + {26'h0, st_q.widx, 2'b00};
        st_d.hdr_wdata = save_word;
        if (st_q.widx == smm_pkg::HDR_LAST) begin
          st_d.seq      = smm_pkg::ST_RUN;
          st_d.ld_entry = 1'b1;
          st_d.flags    = smm_pkg::FLAGS_RST;
          st_d.ctrl0    = smm_pkg::CTRL0_RST;
          st_d.debug    = smm_pkg::DEBUG_RST;
          st_d.ip       = smm_pkg::IP_ENTRY;
          st_d.cs_base  = I_REGION_BASE;
          st_d.cs_limit = I_REGION_SIZE;
          st_d.cs_sel   = I_REGION_BASE[19:4];
          st_d.widx     = smm_pkg::W_DEBUG;
        end else begin
          st_d.widx = st_q.widx + 4'h1;
        end
      end
      smm_pkg::ST_RUN: begin
        if (I_RESUME_INSN) begin
          st_d.seq  = smm_pkg::ST_LOAD;
          st_d.widx = smm_pkg::W_DEBUG;
        end
      end
      smm_pkg::ST_LOAD: begin
        // seven registers restored, read data lags one cycle
        case (st_q.widx)
          4'h1: st_d.debug = mem_rdata;
          4'h2: st_d.flags = mem_rdata;
          4'h3: st_d.ctrl0 = mem_rdata;
          // resume pointer from top minus 14h
          4'h8: st_d.ip = mem_rdata;
          4'h9: st_d.cs_sel = mem_rdata[15:0];
          4'hA: st_d.cs_base = {8'h00, mem_rdata[31:16],
                                st_q.cs_base[7:0]};
          4'hB: st_d.cs_limit = {12'h000, mem_rdata[19:16],
                                 st_q.cs_limit[15:0]};
          default: st_d.flags = st_q.flags;
        endcase
        if (st_q.widx == smm_pkg::HDR_LAST) begin
          st_d.seq       = smm_pkg::ST_EXIT;
          st_d.ld_resume = 1'b1;
          st_d.hi_cnt    = 3'h0;
          st_d.in_prog   = 1'b0;
        end else begin
          st_d.widx = st_q.widx + 4'h1;
        end
      end
      smm_pkg::ST_EXIT: begin
        // pin high two periods after resume
        if (st_q.hi_cnt == smm_pkg::EXIT_HIGH_CYC - 3'h1) begin
          st_d.seq = smm_pkg::ST_IDLE;
        end else begin
          st_d.hi_cnt = st_q.hi_cnt + 3'h1;
        end
      end
      default: begin
        st_d.seq = smm_pkg::ST_IDLE;
      end
    endcase

    if (I_IO_WE && I_IO_ADDR == smm_pkg::IO_INDEX_PORT) begin
      st_d.idx_sel = (I_IO_WDATA == smm_pkg::CFG1_INDEX);
      st_d.io_hit  = 1'b1;
    end else if (I_IO_ADDR == smm_pkg::IO_DATA_PORT && st_q.idx_sel &&
                 (I_IO_WE || I_IO_RE)) begin
      st_d.io_hit  = 1'b1;
      st_d.idx_sel = 1'b0;
      if (I_IO_WE) begin
        st_d.cfg1 = I_IO_WDATA;
      end else begin
        st_d.io_rdata = st_q.cfg1;
      end
    end

    if (I_SPECIAL_INSN && !I_IN_REGION_EXEC &&
        !st_q.cfg1[smm_pkg::SMM_SPACE_ACCESS_EN_BIT] && !st_q.in_prog) begin
      st_d.undef = 1'b1;
    end

    st_d.smm_stb     = 1'b0;
    st_d.nrm_stb     = 1'b0;
    st_d.fetch_fault = 1'b0;
    if (I_ACC_REQ) begin
      if (st_q.in_prog) begin
        if (in_region) begin
          // fetches in overlap stay in management space
          // data without CS prefix to main memory when access bit set
          if (!I_ACC_FETCH && !I_ACC_CS_PREFIX &&
              st_q.cfg1[smm_pkg::MAIN_MEM_ACCESS_EN_BIT]) begin
            st_d.nrm_stb = 1'b1;
          end else begin
            st_d.smm_stb = 1'b1;
          end
        end else begin
          st_d.nrm_stb = 1'b1;
        end
      end else if (in_region && st_q.cfg1[smm_pkg::SMM_SPACE_ACCESS_EN_BIT]) begin
        st_d.smm_stb = 1'b1;
      end else begin
        st_d.nrm_stb = 1'b1;
      end
    end
    st_d.cacheable = st_d.nrm_stb;
    // mask input ignored on management strobe
    st_d.a20_force = st_d.smm_stb | I_ADDR_BIT20_MASK_N;
    st_d.fetch_fault = I_ACC_REQ && I_ACC_FETCH && st_q.in_prog &&
                       in_region && st_q.cfg1[smm_pkg::MAIN_MEM_ACCESS_EN_BIT] &&
                       !I_BUS_READY_N && 1'b0;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      st_q       <= '0;
      st_q.seq   <= smm_pkg::ST_IDLE;
      st_q.cfg1  <= smm_pkg::CFG1_RST;
      st_q.flags <= smm_pkg::FLAGS_RST;
      st_q.ctrl0 <= smm_pkg::CTRL0_RST;
      st_q.debug <= smm_pkg::DEBUG_RST;
    end else if (I_CE) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pin driven low while handler runs
  assign O_SYS_MGMT_IRQ_N    = !st_q.in_prog;
  assign O_SYS_MGMT_IRQ_OE_N = !(st_q.in_prog ||
                                 st_q.seq == smm_pkg::ST_EXIT);
  assign O_IO_RDATA           = st_q.io_rdata;
  assign O_IO_HIT             = st_q.io_hit;
  assign O_SMM_ADDR_STROBE    = st_q.smm_stb;
  assign O_NORMAL_ADDR_STROBE = st_q.nrm_stb;
  assign O_ACC_CACHEABLE      = st_q.cacheable;
  assign O_ACC_A20_FORCE      = st_q.a20_force;
  assign O_FETCH_FAULT        = st_q.fetch_fault;
  assign O_HDR_WE             = st_q.hdr_we;
  assign O_HDR_ADDR           = st_q.hdr_addr;
  assign O_HDR_WDATA          = st_q.hdr_wdata;
  // only these loads; other segments and table untouched
  assign O_LOAD_ENTRY         = st_q.ld_entry;
  assign O_LOAD_RESUME        = st_q.ld_resume;
  assign O_FLAGS              = st_q.flags;
  assign O_CTRL0              = st_q.ctrl0;
  assign O_DEBUG              = st_q.debug;
  assign O_IP                 = st_q.ip;
  assign O_CS_SEL             = st_q.cs_sel;
  assign O_CS_BASE            = st_q.cs_base;
  assign O_CS_LIMIT           = st_q.cs_limit;
  assign O_NMI_ONLY           = st_q.in_prog;
  assign O_UNDEF_OPCODE       = st_q.undef;
  assign O_IN_PROGRESS        = st_q.in_prog;
  // bit positions of the two access bits
  assign O_MAIN_MEM_ACCESS_EN  = st_q.cfg1[smm_pkg::MAIN_MEM_ACCESS_EN_BIT];
  assign O_SMM_SPACE_ACCESS_EN = st_q.cfg1[smm_pkg::SMM_SPACE_ACCESS_EN_BIT];
endmodule
`default_nettype wire

// >>> rtl/smm_pkg.sv
// Purpose: shared constants for the management-mode entry/exit block
// Assumes: byte-addressed header, 32-bit register image
// Notes:   header offsets are counted down from region top
package smm_pkg;
  // ----------------------------------------------------------------
  // header layout, offsets below region base plus size
  // ----------------------------------------------------------------
  localparam logic [31:0] HDR_START_OFS  = 32'h0000_0030;
  localparam logic [31:0] HDR_RESUME_OFS = 32'h0000_0014;
  localparam int          HDR_WORDS      = 12;
  localparam logic [3:0]  HDR_LAST       = 4'hB;
  // word slots of the header, written upward from the start offset
  localparam logic [3:0]  W_DEBUG    = 4'h0;
  localparam logic [3:0]  W_FLAGS    = 4'h1;
  localparam logic [3:0]  W_CTRL0    = 4'h2;
  localparam logic [3:0]  W_CUR_IP   = 4'h3;
  localparam logic [3:0]  W_INDEX    = 4'h4;
  localparam logic [3:0]  W_RESUME   = 4'h7;
  localparam logic [3:0]  W_CS_SEL   = 4'h8;
  localparam logic [3:0]  W_DESC_LO  = 4'h9;
  localparam logic [3:0]  W_DESC_HI  = 4'hA;
  localparam logic [3:0]  W_IND_BITS = 4'hB;
  // ----------------------------------------------------------------
  // register reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
  localparam logic [31:0] CTRL0_RST = 32'h0000_0010;
  localparam logic [31:0] DEBUG_RST = 32'h0000_0400;
  localparam logic [31:0] IP_ENTRY  = 32'h0000_0000;
  localparam logic [7:0]  CFG1_RST  = 8'h00;
  // ----------------------------------------------------------------
  // configuration index/data ports
  // ----------------------------------------------------------------
  localparam logic [15:0] IO_INDEX_PORT = 16'h0022;
  localparam logic [15:0] IO_DATA_PORT  = 16'h0023;
  localparam logic [7:0]  CFG1_INDEX    = 8'hC1;
  localparam int          MAIN_MEM_ACCESS_EN_BIT      = 3;
  localparam int          SMM_SPACE_ACCESS_EN_BIT      = 2;
  // ----------------------------------------------------------------
  // pin timing, in double_clock periods
  // ----------------------------------------------------------------
  localparam logic [2:0]  IRQ_MIN_LOW   = 3'h4;
  localparam logic [2:0]  EXIT_HIGH_CYC = 3'h2;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SAVE  = 5'b00010,
    ST_RUN   = 5'b00100,
    ST_LOAD  = 5'b01000,
    ST_EXIT  = 5'b10000
  } seq_t;
endpackage
